//--- logic/tsts_pkg.sv
// shared constants, types and helpers for the three-slot tuning sequencer
package tsts_pkg;

   // ************************************************************
   // timing figures, in their own units
   // ************************************************************
   localparam int unsigned CLOCK_HZ = 25_000_000;
   localparam int unsigned ARM_DELAY_US = 100;
   localparam int unsigned SHAPE_DELAY_US = 100;
   localparam int unsigned ADVANCE_DELAY_MS = 1;
   localparam int unsigned SLOT_TIME_S = 5;
   localparam int unsigned RESTORE_WAIT_S = 50;
   localparam int unsigned FLASH_HALF_MS = 500;
   localparam int unsigned US_PER_S = 1_000_000;
   localparam int unsigned MS_PER_S = 1_000;
   localparam int unsigned TIMER_W = 32;

   // ************************************************************
   // slot codes held by the two slot-state flops {b, a}
   // ************************************************************
   localparam logic [1:0] SLOT_IDLE = 2'h0;
   localparam logic [1:0] SLOT_COARSE = 2'h1;
   localparam logic [1:0] SLOT_CONVERTER = 2'h2;
   localparam logic [1:0] SLOT_REST = 2'h3;

   // ************************************************************
   // pin indices of the synchronised input vector
   // ************************************************************
   localparam int unsigned PIN_REMOTE = 0;
   localparam int unsigned PIN_LOCAL = 1;
   localparam int unsigned PIN_TEST = 2;
   localparam int unsigned PIN_NULL_N = 3;
   localparam int unsigned PIN_POWER = 4;
   localparam int unsigned PIN_COUNT = 5;

   typedef enum logic [1:0]
   {
      PH_IDLE = 2'b00,
      PH_START = 2'b01,
      PH_TUNE = 2'b10,
      PH_REST = 2'b11
   } tsts_phase_e;

   // relay drives, low energises the relay
   typedef struct packed
   {
      logic coarse_a_n;
      logic coarse_b_n;
      logic conv_a_n;
      logic conv_b_n;
   } tsts_relay_s;

   localparam tsts_relay_s RELAY_OFF = 4'hF;

   // least time: round up, never below one cycle
   function automatic int unsigned cycles_of(input longint unsigned amount,
                                             input longint unsigned per_s,
                                             input longint unsigned clk_hz);
      longint unsigned c;
      c = (amount * clk_hz + per_s - 1) / per_s;
      if (c < 1)
      begin
         c = 1;
      end
      return 32'(c);
   endfunction

endpackage

//--- logic/tsts_sync.sv
// two-flop synchronisers for the switch and relay inputs
`timescale 1ns/1ps
module tsts_sync #(
   parameter int WIDTH = 5
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // pins and their synchronised copies
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] sync_q
);

   logic [WIDTH-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge clock)
         begin
            if (reset)
            begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= pin[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

endmodule

//--- logic/tsts_delay.sv
// retriggerable one-shot delay stage counting clock cycles
`timescale 1ns/1ps
module tsts_delay #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // control
   input wire logic clear,
   input wire logic fire,
   input wire logic [WIDTH-1:0] cycles,
   // result
   output logic done_q
);

   logic [WIDTH-1:0] count_q;
   logic busy_q;

   // done pulses exactly cycles edges after the fire edge
   always_ff @(posedge clock)
   begin
      if (reset || clear)
      begin
         count_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (fire)
      begin
         count_q <= cycles;
         busy_q <= 1'b1;
         done_q <= 1'b0;
      end
      else if (busy_q && count_q <= WIDTH'(1))
      begin
         busy_q <= 1'b0;
         done_q <= 1'b1;
      end
      else
      begin
         count_q <= busy_q ? count_q - WIDTH'(1) : count_q;
         done_q <= 1'b0;
      end
   end

endmodule

//--- logic/tsts_sequencer.sv
// three-slot tuning sequencer: start triggers, slot timer, relay coder, fault lamp
//
// Behaviour
// - every start request first clears both slot-state flops and the slot-timer flop
// - first advance waits a 100 us stage then a 1 ms stage
// - each advance steps slot flops and toggles timer flop; first advance gives slot 1
// - logical one is -12 V, zero is 0 V; relays energise on a driven zero
// - slot 1 drives the coarse-tune relay pair low
// - after each advance a 5 s timer, a 100 us shaper and 1 ms stage advance again
// - the timer pulse advances only in slots 1 and 2
// - slot 2 adds the converter-tune pair low and keeps the coarse pair low
// - slot 3 releases all four relays and asserts rest, arming null detection
// - armed null detect at zero gates the free-running oscillator onto the fault lamp
// - loop error during rest restarts the sequence from its reset step
// - power restore waits 50 s then starts like an autotune start pulse
// - restarted sequence keeps the selected frequency; channel selection is untouched
// - local start switch acts like the remote interlock start pulse, and also in test position, where the remote start is ignored
// - slot order, timing and relays are the same for every channel
`timescale 1ns/1ps
module tsts_sequencer
   import tsts_pkg::*;
#(
   parameter int unsigned CLOCK_HZ_P = tsts_pkg::CLOCK_HZ,
   parameter int unsigned ADVANCE_CYCLES =
      tsts_pkg::cycles_of(tsts_pkg::ADVANCE_DELAY_MS, tsts_pkg::MS_PER_S, CLOCK_HZ_P),
   parameter int unsigned SLOT_CYCLES =
      tsts_pkg::cycles_of(tsts_pkg::SLOT_TIME_S, 1, CLOCK_HZ_P),
   parameter int unsigned RESTORE_CYCLES =
      tsts_pkg::cycles_of(tsts_pkg::RESTORE_WAIT_S, 1, CLOCK_HZ_P),
   parameter int unsigned FLASH_CYCLES =
      tsts_pkg::cycles_of(tsts_pkg::FLASH_HALF_MS, tsts_pkg::MS_PER_S, CLOCK_HZ_P)
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // start sources
   input wire logic reverse_interlock_switch,
   input wire logic local_start_switch,
   input wire logic normal_test_select,
   input wire logic power_ok,
   // null detector, zero means loop error
   input wire logic null_detect_relay_n,
   // relay drives and indicators
   output tsts_pkg::tsts_relay_s relays_q,
   output logic rest_q,
   output logic fault_lamp_q,
   // status
   output logic [1:0] slot_q,
   output tsts_pkg::tsts_phase_e phase_q
);
   import tsts_pkg::*;

   localparam int unsigned STAGE_CYCLES = cycles_of(ARM_DELAY_US, US_PER_S, CLOCK_HZ_P);
   localparam int unsigned SHAPE_CYCLES = cycles_of(SHAPE_DELAY_US, US_PER_S, CLOCK_HZ_P);

   // ************************************************************
   // input synchronisation and edge detection
   // ************************************************************
   logic [PIN_COUNT-1:0] sync_q;
   logic [PIN_COUNT-1:0] prev_q;

   tsts_sync #(.WIDTH(PIN_COUNT)) u_sync (
      .clock(clock),
      .reset(reset),
      .pin({power_ok, null_detect_relay_n, normal_test_select, local_start_switch,
            reverse_interlock_switch}), // msb first, in pin index order
      .sync_q(sync_q)
   );

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         prev_q <= '0;
      end
      else
      begin
         prev_q <= sync_q;
      end
   end

   logic remote_start;
   logic local_start;
   logic power_rise;
   // in test position the remote interlock is ignored; local start still acts
   assign remote_start = sync_q[PIN_REMOTE] && !prev_q[PIN_REMOTE] && !sync_q[PIN_TEST];
   assign local_start = sync_q[PIN_LOCAL] && !prev_q[PIN_LOCAL];
   assign power_rise = sync_q[PIN_POWER] && !prev_q[PIN_POWER];

   // ************************************************************
   // slot decoding
   // ************************************************************
   logic slot_state_flop_a_q;
   logic slot_state_flop_b_q;
   logic slot_timer_flop_q;
   logic [1:0] slot;

   function automatic logic slot_enables_timer(input logic [1:0] s);
      return (s == SLOT_COARSE) || (s == SLOT_CONVERTER);
   endfunction

   assign slot = {slot_state_flop_b_q, slot_state_flop_a_q};

   // ************************************************************
   // start requests
   // ************************************************************
   logic restore_done;
   logic null_error;
   logic start_req;
   logic start_q;

   assign null_error = (slot == SLOT_REST) && !sync_q[PIN_NULL_N];
   // restart keeps no channel state here, so the tuned frequency is unchanged
   assign start_req = remote_start || local_start || restore_done || null_error;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         start_q <= 1'b0;
      end
      else
      begin
         start_q <= start_req;
      end
   end

   // ************************************************************
   // delay stages
   // ************************************************************
   logic arm_done;
   logic slot_done;
   logic shape_fire;
   logic shape_done;
   logic advance;

   tsts_delay #(.WIDTH(TIMER_W)) u_arm (
      .clock(clock),
      .reset(reset),
      .clear(start_req),
      .fire(start_q),
      .cycles(TIMER_W'(STAGE_CYCLES)),
      .done_q(arm_done)
   );

   // the timer restarts on every toggle of the slot-timer flop
   tsts_delay #(.WIDTH(TIMER_W)) u_slot (
      .clock(clock),
      .reset(reset),
      .clear(start_req),
      .fire(advance),
      .cycles(TIMER_W'(SLOT_CYCLES)),
      .done_q(slot_done)
   );

   assign shape_fire = slot_done && slot_enables_timer(slot);

   tsts_delay #(.WIDTH(TIMER_W)) u_shape (
      .clock(clock),
      .reset(reset),
      .clear(start_req),
      .fire(shape_fire),
      .cycles(TIMER_W'(SHAPE_CYCLES)),
      .done_q(shape_done)
   );

   // one 1 ms stage serves both the start path and the timer path
   tsts_delay #(.WIDTH(TIMER_W)) u_advance (
      .clock(clock),
      .reset(reset),
      .clear(start_req),
      .fire(arm_done || shape_done),
      .cycles(TIMER_W'(ADVANCE_CYCLES)),
      .done_q(advance)
   );

   // a new power event restarts the wait, a power loss cancels it; a start does not
   tsts_delay #(.WIDTH(TIMER_W)) u_restore (
      .clock(clock),
      .reset(reset),
      .clear(!sync_q[PIN_POWER]),
      .fire(power_rise),
      .cycles(TIMER_W'(RESTORE_CYCLES)),
      .done_q(restore_done)
   );

   // ************************************************************
   // slot-state and slot-timer flops
   // ************************************************************
   always_ff @(posedge clock)
   begin
      if (reset || start_req)
      begin
         slot_state_flop_a_q <= 1'b0;
         slot_state_flop_b_q <= 1'b0;
         slot_timer_flop_q <= 1'b0;
      end
      else if (advance && slot != SLOT_REST)
      begin
         {slot_state_flop_b_q, slot_state_flop_a_q} <= slot + 2'h1;
         slot_timer_flop_q <= !slot_timer_flop_q;
      end
   end

   // ************************************************************
   // relay coder and status, identical for every channel
   // ************************************************************
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         relays_q <= RELAY_OFF;
         rest_q <= 1'b0;
         slot_q <= SLOT_IDLE;
         phase_q <= PH_IDLE;
      end
      else
      begin
         slot_q <= slot;
         rest_q <= (slot == SLOT_REST);
         relays_q <= RELAY_OFF;
         // start_q, not start_req: a restart from a busy slot meets idle one edge later
         case (slot)
            SLOT_IDLE: phase_q <= (start_q || phase_q == PH_START) ? PH_START : PH_IDLE;
            SLOT_COARSE: phase_q <= PH_TUNE;
            SLOT_CONVERTER: phase_q <= PH_TUNE;
            SLOT_REST: phase_q <= PH_REST;
            default: phase_q <= PH_IDLE;
         endcase
         if (slot == SLOT_COARSE || slot == SLOT_CONVERTER)
         begin
            relays_q.coarse_a_n <= 1'b0;
            relays_q.coarse_b_n <= 1'b0;
         end
         if (slot == SLOT_CONVERTER)
         begin
            relays_q.conv_a_n <= 1'b0;
            relays_q.conv_b_n <= 1'b0;
         end
      end
   end

   // ************************************************************
   // fault lamp
   // ************************************************************
   logic [TIMER_W-1:0] osc_cnt_q;
   logic osc_q;
   logic fault_q;

   // free-running so the flash phase is independent of the error moment
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         osc_cnt_q <= '0;
         osc_q <= 1'b0;
      end
      else if (osc_cnt_q >= TIMER_W'(FLASH_CYCLES - 1))
      begin
         osc_cnt_q <= '0;
         osc_q <= !osc_q;
      end
      else
      begin
         osc_cnt_q <= osc_cnt_q + TIMER_W'(1);
      end
   end

   // latched, since the restart leaves rest at once; a new error beats a clear
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         fault_q <= 1'b0;
         fault_lamp_q <= 1'b0;
      end
      else
      begin
         fault_lamp_q <= fault_q && osc_q;
         if (null_error)
         begin
            fault_q <= 1'b1;
         end
         else if (remote_start || local_start || restore_done)
         begin
            fault_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence flops_cleared;
      slot == SLOT_IDLE && !slot_timer_flop_q;
   endsequence

   reset_clear_a: assert property (start_req |=> flops_cleared)
      else $error("start did not clear slot flops");
   arm_quiet_a: assert property (start_req |=> !advance [*8])
      else $error("advance came too soon after start");
   first_slot_a: assert property (advance && slot == SLOT_IDLE && !start_req
                                  |=> slot == SLOT_COARSE)
      else $error("first advance did not enter slot 1");
   timer_toggle_a: assert property (advance && slot != SLOT_REST && !start_req
                                    |=> slot_timer_flop_q != $past(slot_timer_flop_q))
      else $error("timer flop did not toggle on advance");
   coarse_relay_a: assert property ($past(slot) == SLOT_COARSE
      |-> !relays_q.coarse_a_n && !relays_q.coarse_b_n && relays_q.conv_a_n)
      else $error("slot 1 relays wrong");
   conv_relay_a: assert property ($past(slot) == SLOT_CONVERTER
      |-> relays_q == 4'h0)
      else $error("slot 2 relays wrong");
   rest_release_a: assert property ($past(slot) == SLOT_REST
      |-> relays_q == RELAY_OFF && rest_q)
      else $error("slot 3 relays or rest wrong");
   timer_gate_a: assert property (slot == SLOT_REST |-> !shape_done)
      else $error("timer pulse passed in rest slot");
   null_restart_a: assert property (slot == SLOT_REST && !sync_q[PIN_NULL_N]
                                    |-> start_req ##1 slot == SLOT_IDLE)
      else $error("loop error did not restart");
   rest_hold_a: assert property (slot == SLOT_REST && !start_req
                                 |=> slot == SLOT_REST)
      else $error("rest slot left without a request");
   lamp_dark_a: assert property (!fault_q |=> !fault_lamp_q)
      else $error("fault lamp lit without fault");
   restore_start_a: assert property (restore_done |=> flops_cleared)
      else $error("power restore did not start sequence");

endmodule

//--- tb/tsts_far_side.sv
// far-side model: interlock, local switch, selector, power sense and null relay
`timescale 1ns/1ps
module tsts_far_side (
   // clock
   input wire logic clock,
   // device status seen by the null detector
   input wire logic rest_q,
   // pins into the sequencer
   output logic reverse_interlock_switch,
   output logic local_start_switch,
   output logic normal_test_select,
   output logic power_ok,
   output logic null_detect_relay_n
);
   // ************************************************************
   // pin drivers, all changed on the rising edge
   // ************************************************************
   logic loop_bad_q = 1'b0;

   initial
   begin
      reverse_interlock_switch = 1'b0;
      local_start_switch = 1'b0;
      normal_test_select = 1'b0;
      power_ok = 1'b0;
      null_detect_relay_n = 1'b1;
   end

   // null relay only sits in the loop while rest is armed
   always @(posedge clock)
   begin
      null_detect_relay_n <= ~(loop_bad_q & rest_q);
   end

   // start pulse held four cycles so the synchronisers see it
   task automatic pulse(input bit use_local);
      @(posedge clock);
      if (use_local)
      begin
         local_start_switch <= 1'b1;
      end
      else
      begin
         reverse_interlock_switch <= 1'b1;
      end
      repeat (4) @(posedge clock);
      local_start_switch <= 1'b0;
      reverse_interlock_switch <= 1'b0;
   endtask

   task automatic set_test(input bit v);
      @(posedge clock);
      normal_test_select <= v;
   endtask

   task automatic set_power(input bit v);
      @(posedge clock);
      power_ok <= v;
   endtask

   task automatic set_loop(input bit v);
      @(posedge clock);
      loop_bad_q <= v;
   endtask
endmodule

//--- tb/tb_tsts_sequencer.sv
// self-checking bench for the three-slot tuning sequencer
`timescale 1ns/1ps
module tb_tsts_sequencer;
   import tsts_pkg::*;
   // ************************************************************
   // shortened timing, 100 us stages are 10 cycles at this rate
   // ************************************************************
   localparam int HZ = 100000;
   localparam int ARM = 10;
   localparam int ADV = 20;
   localparam int SLOT = 200;
   localparam int RST = 300;
   localparam int FLASH = 8;
   localparam int LAP = SLOT + ARM + ADV;

   logic clock = 1'b0;
   logic reset = 1'b1;
   logic reverse_interlock_switch;
   logic local_start_switch;
   logic normal_test_select;
   logic power_ok;
   logic null_detect_relay_n;
   tsts_relay_s relays_q;
   logic rest_q;
   logic fault_lamp_q;
   logic [1:0] slot_q;
   tsts_phase_e phase_q;
   int err_count = 0;
   int samples_checked = 0;
   int n;

   always #20 clock = ~clock;

   tsts_sequencer #(.CLOCK_HZ_P(HZ), .ADVANCE_CYCLES(ADV), .SLOT_CYCLES(SLOT),
      .RESTORE_CYCLES(RST), .FLASH_CYCLES(FLASH)) uut (
      .clock(clock), .reset(reset),
      .reverse_interlock_switch(reverse_interlock_switch),
      .local_start_switch(local_start_switch),
      .normal_test_select(normal_test_select), .power_ok(power_ok),
      .null_detect_relay_n(null_detect_relay_n), .relays_q(relays_q),
      .rest_q(rest_q), .fault_lamp_q(fault_lamp_q), .slot_q(slot_q), .phase_q(phase_q));

   tsts_far_side far (
      .clock(clock), .rest_q(rest_q),
      .reverse_interlock_switch(reverse_interlock_switch),
      .local_start_switch(local_start_switch),
      .normal_test_select(normal_test_select), .power_ok(power_ok),
      .null_detect_relay_n(null_detect_relay_n));

   // ************************************************************
   // compare, wait and closing tasks
   // ************************************************************
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi)
      begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   // bounded waits sample at the falling edge, where outputs are settled
   task automatic wait_slot(input logic [1:0] code, input int max, output int cnt);
      cnt = 0;
      while (slot_q !== code && cnt < max)
      begin
         @(negedge clock);
         cnt++;
      end
   endtask

   task automatic wait_lamp(input logic v, input int max, output int cnt);
      cnt = 0;
      while (fault_lamp_q !== v && cnt < max)
      begin
         @(negedge clock);
         cnt++;
      end
   endtask

   task automatic wrap_up;
      $display("err_count=%0d samples_checked=%0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // the whole run needs some 2500 cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      err_count++;
      wrap_up();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      chk_val(8'(relays_q), 8'h0F);
      chk_val({7'h00, rest_q}, 8'h00);
      chk_val({7'h00, fault_lamp_q}, 8'h00);
      chk_val({6'h00, slot_q}, 8'h00);
      chk_val(8'(phase_q), 8'(PH_IDLE));
      // remote start runs the three slots
      far.pulse(1'b0);
      wait_slot(2'h1, 100, n);
      chk_rng(n + 4, ARM + ADV, ARM + ADV + 10);
      chk_val(8'(relays_q), 8'h03);
      chk_val(8'(phase_q), 8'(PH_TUNE));
      wait_slot(2'h2, LAP + 20, n);
      chk_rng(n, LAP - 1, LAP + 6);
      chk_val(8'(relays_q), 8'h00);
      wait_slot(2'h3, LAP + 20, n);
      chk_rng(n, LAP - 1, LAP + 6);
      chk_val(8'(relays_q), 8'h0F);
      chk_val({7'h00, rest_q}, 8'h01);
      chk_val(8'(phase_q), 8'(PH_REST));
      repeat (3 * SLOT) @(negedge clock);
      chk_val({6'h00, slot_q}, 8'h03);
      chk_val({7'h00, rest_q}, 8'h01);
      // loop error in rest restarts and flashes the lamp
      far.set_loop(1'b1);
      wait_slot(2'h0, 20, n);
      chk_rng(n, 1, 12);
      wait_lamp(1'b1, 5 * FLASH, n);
      chk_rng(n, 0, 4 * FLASH);
      wait_lamp(1'b0, 5 * FLASH, n);
      chk_rng(n, 1, FLASH + 2);
      wait_lamp(1'b1, 5 * FLASH, n);
      chk_rng(n, FLASH - 2, FLASH + 2);
      far.set_loop(1'b0);
      wait_slot(2'h1, 100, n);
      chk_val(8'(relays_q), 8'h03);
      // test position: remote ignored, local start restarts
      wait_slot(2'h3, 3 * LAP, n);
      far.set_test(1'b1);
      far.pulse(1'b0);
      repeat (60) @(negedge clock);
      chk_val({6'h00, slot_q}, 8'h03);
      far.pulse(1'b1);
      @(negedge clock);
      chk_val(8'(phase_q), 8'(PH_START));
      wait_slot(2'h1, 100, n);
      chk_rng(n + 4, ARM + ADV, ARM + ADV + 10);
      chk_val({7'h00, fault_lamp_q}, 8'h00);
      far.set_test(1'b0);
      // power restore waits, then starts afresh
      wait_slot(2'h3, 3 * LAP, n);
      far.set_power(1'b1);
      wait_slot(2'h0, RST + 40, n);
      chk_rng(n, RST, RST + 10);
      wait_slot(2'h1, 100, n);
      chk_rng(n, ARM + ADV - 2, ARM + ADV + 6);
      chk_val(8'(relays_q), 8'h03);
      wrap_up();
   end
endmodule
